// ===== include/irq_wake_pkg.sv
package irq_wake_pkg;
    localparam int num_sources = 13;
    localparam int src_idx_width = 4;
    localparam int usb_src_count = 21;
    localparam logic [7:0] vector_base = 8'h03;
    localparam logic [7:0] vector_step = 8'h08;
    localparam logic [7:0] vector_none = 8'h00;
    // Source index equals natural priority; resume is 0
    localparam logic [3:0] idx_resume = 4'h0;
    localparam logic [3:0] idx_ext0 = 4'h1;
    localparam logic [3:0] idx_timer0 = 4'h2;
    localparam logic [3:0] idx_ext1 = 4'h3;
    localparam logic [3:0] idx_timer1 = 4'h4;
    localparam logic [3:0] idx_uart0 = 4'h5;
    localparam logic [3:0] idx_timer2 = 4'h6;
    localparam logic [3:0] idx_uart1 = 4'h7;
    localparam logic [3:0] idx_usb = 4'h8;
    localparam logic [3:0] idx_serial_bus = 4'h9;
    localparam logic [3:0] idx_ext4 = 4'hA;
    localparam logic [3:0] idx_ext5 = 4'hB;
    localparam logic [3:0] idx_ext6 = 4'hC;
    // Vector slot per source (slot*8+3)
    localparam logic [7:0] slot_of [num_sources] = '{8'h06, 8'h00, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    localparam int suspend_time_us = 3000;
    localparam int clk_mhz = 25;
    localparam int suspend_cycles = suspend_time_us * clk_mhz;
    localparam int sync_stages = 3;

    typedef enum logic [1:0] {
        pw_run = 2'b00,
        pw_suspended = 2'b01,
        pw_idle = 2'b10
    } power_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [3:0] priority_rank;
        logic high_group;
    } irq_grant_type;

    typedef struct packed {
        logic usb_irq_pending_flag;
        logic resume_irq_flag;
    } flag_view_type;
endpackage : irq_wake_pkg

// ===== rtl/core_interrupt_and_wakeup.sv
// Notes on behaviour
// RULE1 - Fixed vectors from 03 spaced by 8
// RULE2 - Resume from wakeup pin or USB core
// RULE3 - Two priority groups, ties by natural rank
// RULE4 - Core drives resume, USB, serial bus sources
// RULE5 - All 21 USB requests share one input
// RULE6 - Suspend request after 3 ms bus silence
// RULE7 - Idle bit after suspend stops the oscillator
// RULE8 - Idle halts until enabled interrupt active
// RULE9 - Wakeup or bus activity restarts oscillator
// RULE10 - Resume on global resume or low wakeup
// RULE11 - Wakeup acts only when suspended and idle
// RULE12 - Software enables resume via enable bit
// RULE13 - Resume flag readable, cleared by zero write
// RULE14 - USB pending flag, enable, zero-write clear
// RULE15 - Pulse shared input per new request
// RULE16 - Flags stay set until software clears
module core_interrupt_and_wakeup #(
    parameter int suspend_count = irq_wake_pkg::suspend_cycles
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [irq_wake_pkg::usb_src_count-1:0] usb_src_set_in,
    input wire logic serial_bus_irq_input_in,
    input wire logic [irq_wake_pkg::num_sources-1:0] other_src_in,
    input wire logic [irq_wake_pkg::num_sources-1:0] src_enable_in,
    input wire logic [irq_wake_pkg::num_sources-1:0] src_high_group_in,
    input wire logic global_enable_in,
    input wire logic bus_activity_in,
    input wire logic global_resume_in,
    input wire logic wakeup_n_in,
    input wire logic idle_request_bit_in,
    input wire logic resume_irq_enable_in,
    input wire logic usb_irq_enable_in,
    input wire logic resume_flag_clear_in,
    input wire logic usb_flag_clear_in,
    output logic shared_usb_irq_input_out,
    output logic serial_bus_irq_input_out,
    output logic suspend_request_out,
    output logic osc_enable_out,
    output logic cpu_halt_out,
    output irq_wake_pkg::flag_view_type flags_out,
    output irq_wake_pkg::irq_grant_type grant_out
);
    localparam int cnt_w = $clog2(suspend_count + 1);
    localparam int n = irq_wake_pkg::num_sources;

    function automatic logic [7:0] vector_of(input logic [3:0] idx);
        vector_of = irq_wake_pkg::vector_base
            + 8'(irq_wake_pkg::slot_of[idx] * irq_wake_pkg::vector_step); // RULE1
    endfunction : vector_of

    // Pin inputs: three stages, change accepted when stages two and three agree
    logic [2:0] wake_sync_q, wake_sync_d;
    logic [2:0] act_sync_q, act_sync_d;
    logic [2:0] gres_sync_q, gres_sync_d;
    logic wake_low_q, wake_low_d;
    logic act_q, act_d;
    logic gres_q, gres_d;

    always_comb begin
        wake_sync_d = {wake_sync_q[1:0], ~wakeup_n_in};
        act_sync_d = {act_sync_q[1:0], bus_activity_in};
        gres_sync_d = {gres_sync_q[1:0], global_resume_in};
        wake_low_d = (wake_sync_q[1] == wake_sync_q[2]) ? wake_sync_q[2] : wake_low_q;
        act_d = (act_sync_q[1] == act_sync_q[2]) ? act_sync_q[2] : act_q;
        gres_d = (gres_sync_q[1] == gres_sync_q[2]) ? gres_sync_q[2] : gres_q;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_sync_q <= 3'h0;
            act_sync_q <= 3'h0;
            gres_sync_q <= 3'h0;
            wake_low_q <= 1'b0;
            act_q <= 1'b0;
            gres_q <= 1'b0;
        end else begin
            wake_sync_q <= wake_sync_d;
            act_sync_q <= act_sync_d;
            gres_sync_q <= gres_sync_d;
            wake_low_q <= wake_low_d;
            act_q <= act_d;
            gres_q <= gres_d;
        end
    end

    // Suspend detection and power state
    logic [cnt_w-1:0] idle_cnt_q, idle_cnt_d;
    logic susp_q, susp_d;
    irq_wake_pkg::power_state_type pw_q, pw_d;
    logic wake_event;

    assign wake_event = wake_low_q || act_q || gres_q;

    always_comb begin
        idle_cnt_d = idle_cnt_q;
        susp_d = 1'b0;
        pw_d = pw_q;
        if (act_q) begin
            idle_cnt_d = '0;
        end else if (idle_cnt_q != cnt_w'(suspend_count)) begin
            idle_cnt_d = idle_cnt_q + 1'b1;
            susp_d = (idle_cnt_q == cnt_w'(suspend_count - 1)); // RULE6
        end
        unique case (pw_q)
            irq_wake_pkg::pw_run: begin
                if (susp_q) begin
                    pw_d = irq_wake_pkg::pw_suspended;
                end
            end
            irq_wake_pkg::pw_suspended: begin
                if (idle_request_bit_in) begin
                    pw_d = irq_wake_pkg::pw_idle; // RULE7
                end else if (act_q) begin
                    pw_d = irq_wake_pkg::pw_run;
                end
            end
            irq_wake_pkg::pw_idle: begin
                if (wake_event) begin
                    pw_d = irq_wake_pkg::pw_run; // RULE9 RULE11
                end
            end
            default: pw_d = irq_wake_pkg::pw_run;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_cnt_q <= '0;
            susp_q <= 1'b0;
            pw_q <= irq_wake_pkg::pw_run;
        end else begin
            idle_cnt_q <= idle_cnt_d;
            susp_q <= susp_d;
            pw_q <= pw_d;
        end
    end

    // Interrupt latches
    logic [irq_wake_pkg::usb_src_count-1:0] usb_prev_q, usb_prev_d;
    logic usb_flag_q, usb_flag_d;
    logic res_flag_q, res_flag_d;
    logic usb_pulse_q, usb_pulse_d;
    logic sb_prev_q, sb_prev_d;
    logic sb_pulse_q, sb_pulse_d;
    logic [n-1:0] req;
    logic new_usb;
    logic resume_set;

    always_comb begin
        usb_prev_d = usb_src_set_in;
        sb_prev_d = serial_bus_irq_input_in;
        new_usb = |(usb_src_set_in & ~usb_prev_q); // RULE5
        usb_pulse_d = new_usb; // RULE15
        sb_pulse_d = serial_bus_irq_input_in && !sb_prev_q;
        resume_set = (pw_q == irq_wake_pkg::pw_idle) && (wake_low_q || gres_q); // RULE10 RULE2
        // Set wins over a same-cycle clear
        usb_flag_d = usb_pulse_q || (usb_flag_q && !usb_flag_clear_in); // RULE14 RULE16
        res_flag_d = resume_set || (res_flag_q && !resume_flag_clear_in); // RULE13 RULE16
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            usb_prev_q <= '0;
            usb_flag_q <= 1'b0;
            res_flag_q <= 1'b0;
            usb_pulse_q <= 1'b0;
            sb_prev_q <= 1'b0;
            sb_pulse_q <= 1'b0;
        end else begin
            usb_prev_q <= usb_prev_d;
            usb_flag_q <= usb_flag_d;
            res_flag_q <= res_flag_d;
            usb_pulse_q <= usb_pulse_d;
            sb_prev_q <= sb_prev_d;
            sb_pulse_q <= sb_pulse_d;
        end
    end

    // Priority resolution
    irq_wake_pkg::irq_grant_type grant_q, grant_d;

    always_comb begin
        req = other_src_in & src_enable_in;
        req[irq_wake_pkg::idx_resume] = res_flag_q && resume_irq_enable_in; // RULE12 RULE4
        req[irq_wake_pkg::idx_usb] = usb_flag_q && usb_irq_enable_in; // RULE4
        req[irq_wake_pkg::idx_serial_bus] = sb_pulse_q || other_src_in[irq_wake_pkg::idx_serial_bus];
        req[irq_wake_pkg::idx_serial_bus] = req[irq_wake_pkg::idx_serial_bus]
            && src_enable_in[irq_wake_pkg::idx_serial_bus];
        if (!global_enable_in) begin
            req = '0;
        end
        grant_d = '0;
        for (int i = n - 1; i >= 0; i--) begin
            if (req[i] && !src_high_group_in[i] && !grant_d.high_group) begin
                grant_d.valid = 1'b1;
                grant_d.priority_rank = 4'(i);
                grant_d.vector = vector_of(4'(i));
            end
        end
        for (int i = n - 1; i >= 0; i--) begin
            if (req[i] && src_high_group_in[i]) begin
                grant_d = '{valid: 1'b1, vector: vector_of(4'(i)), priority_rank: 4'(i),
                    high_group: 1'b1}; // RULE3
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            grant_q <= '0;
        end else begin
            grant_q <= grant_d;
        end
    end

    assign shared_usb_irq_input_out = usb_pulse_q;
    assign serial_bus_irq_input_out = sb_pulse_q;
    assign suspend_request_out = susp_q;
    assign osc_enable_out = (pw_q != irq_wake_pkg::pw_idle); // RULE7
    assign cpu_halt_out = (pw_q == irq_wake_pkg::pw_idle) && !(|req); // RULE8
    assign flags_out = '{usb_irq_pending_flag: usb_flag_q, resume_irq_flag: res_flag_q};
    assign grant_out = grant_q;

    suspend_after_silence_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(susp_q) |-> $past(idle_cnt_q) == cnt_w'(suspend_count - 1)) // RULE6
        else $error("suspend request at wrong count");
    osc_stops_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pw_q == irq_wake_pkg::pw_suspended && idle_request_bit_in) |=> !osc_enable_out) // RULE7
        else $error("oscillator not stopped after idle bit");
    wake_restarts_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pw_q == irq_wake_pkg::pw_idle && wake_low_q) |=> osc_enable_out) // RULE9
        else $error("oscillator not restarted by wakeup");
    resume_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pw_q == irq_wake_pkg::pw_idle && gres_q) |=> res_flag_q) // RULE10
        else $error("resume flag not set");
    resume_sticky_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (res_flag_q && !resume_flag_clear_in) |=> res_flag_q) // RULE16
        else $error("resume flag dropped without clear");
    usb_flag_pulse_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        shared_usb_irq_input_out |=> flags_out.usb_irq_pending_flag) // RULE14
        else $error("usb flag not set by pulse");
    usb_pulse_new_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (|(usb_src_set_in & ~usb_prev_q)) |=> shared_usb_irq_input_out) // RULE15
        else $error("no pulse for new usb request");
    halt_until_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        cpu_halt_out |-> (!grant_d.valid && !osc_enable_out)) // RULE8
        else $error("halt held with interrupt active");
    high_group_wins_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (|(req & src_high_group_in)) |=> grant_out.high_group && grant_out.valid) // RULE3
        else $error("high group not preferred");
    usb_vector_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (req == (n'(1) << irq_wake_pkg::idx_usb)) |=> grant_out.vector == 8'h43) // RULE1
        else $error("usb vector wrong");
endmodule : core_interrupt_and_wakeup

// ===== tb/proc_wake_model.sv
module proc_wake_model (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic suspend_request_in,
    input wire logic osc_enable_in,
    input wire logic wake_cmd_in,
    output logic idle_request_bit_out,
    output logic wakeup_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hk_q;
    logic off_q;
    // Pin pulled low while external logic asks for wakeup
    assign wakeup_n_out = ~wake_cmd_in;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hk_q <= 3'h0;
            off_q <= 1'b0;
            idle_request_bit_out <= 1'b0;
        end else if (suspend_request_in) begin
            hk_q <= 3'h4;
        end else if (hk_q != 3'h0) begin
            hk_q <= hk_q - 3'h1;
            // Housekeeping done, enter idle
            if (hk_q == 3'h1) idle_request_bit_out <= 1'b1;
        end else if (idle_request_bit_out && !osc_enable_in) begin
            off_q <= 1'b1;
        end else if (off_q && osc_enable_in) begin
            // Clock back, processor leaves idle
            off_q <= 1'b0;
            idle_request_bit_out <= 1'b0;
        end
    end
endmodule : proc_wake_model

// ===== tb/core_interrupt_and_wakeup_tb.sv
`define check_eq(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module core_interrupt_and_wakeup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [20:0] usb_src = '0;
    logic [12:0] oth = '0, en = '1, hg = '0;
    logic ser = 1'b0, gen = 1'b1, bus_act = 1'b1, gres = 1'b0, wake_cmd = 1'b0;
    logic res_en = 1'b0, usb_en = 1'b0, rclr = 1'b0, uclr = 1'b0;
    logic usb_p, ser_p, sus_p, osc, halt, idle, wake_n;
    irq_wake_pkg::flag_view_type flags;
    irq_wake_pkg::irq_grant_type gnt;
    int fail_count = 0, num_checks = 0, n_usb = 0, n_ser = 0, n_sus = 0;
    logic [7:0] vec [13] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B, 8'h43,
        8'h4B, 8'h53, 8'h5B, 8'h63};
    core_interrupt_and_wakeup #(.suspend_count(50)) core_interrupt_and_wakeup_i (
        .core_clk_in(clk), .rst_n_in(rst_n), .usb_src_set_in(usb_src),
        .serial_bus_irq_input_in(ser), .other_src_in(oth), .src_enable_in(en),
        .src_high_group_in(hg), .global_enable_in(gen), .bus_activity_in(bus_act),
        .global_resume_in(gres), .wakeup_n_in(wake_n), .idle_request_bit_in(idle),
        .resume_irq_enable_in(res_en), .usb_irq_enable_in(usb_en),
        .resume_flag_clear_in(rclr), .usb_flag_clear_in(uclr),
        .shared_usb_irq_input_out(usb_p), .serial_bus_irq_input_out(ser_p),
        .suspend_request_out(sus_p), .osc_enable_out(osc), .cpu_halt_out(halt),
        .flags_out(flags), .grant_out(gnt));
    proc_wake_model proc_wake_model_i (
        .core_clk_in(clk), .rst_n_in(rst_n), .suspend_request_in(sus_p),
        .osc_enable_in(osc), .wake_cmd_in(wake_cmd), .idle_request_bit_out(idle),
        .wakeup_n_out(wake_n));
    always #20 clk = ~clk;
    // Pulse tallies
    always @(posedge clk) begin
        if (usb_p === 1'b1) n_usb++;
        if (ser_p === 1'b1) n_ser++;
        if (sus_p === 1'b1) n_sus++;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #(40 * 3000);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        `check_eq("reset osc", 1'b1, osc)
        `check_eq("reset flags", 2'b00, flags)
        for (int i = 0; i < 21; i++) begin
            @(posedge clk) usb_src <= 21'h1 << i;
            @(posedge clk) usb_src <= '0;
            cyc(2);
        end
        cyc(2);
        `check_eq("usb pulses", 21, n_usb)
        `check_eq("usb pending", 1'b1, flags.usb_irq_pending_flag)
        `check_eq("usb masked", 1'b0, gnt.valid)
        @(posedge clk) usb_en <= 1'b1;
        cyc(3);
        `check_eq("usb vector", 8'h43, gnt.vector)
        @(posedge clk) uclr <= 1'b1;
        @(posedge clk) uclr <= 1'b0;
        cyc(3);
        `check_eq("usb clear", 1'b0, flags.usb_irq_pending_flag)
        for (int i = 1; i < 13; i++) begin
            if (i == 8) continue;
            @(posedge clk) oth <= 13'h1 << i;
            cyc(3);
            `check_eq("vector", vec[i], gnt.vector)
            `check_eq("rank", 4'(i), gnt.priority_rank)
        end
        @(posedge clk) oth <= 13'h0408;
        cyc(3);
        `check_eq("low tie", 4'h3, gnt.priority_rank)
        @(posedge clk) hg <= 13'h0400;
        cyc(3);
        `check_eq("high group", 4'hA, gnt.priority_rank)
        `check_eq("high flag", 1'b1, gnt.high_group)
        @(posedge clk) gen <= 1'b0;
        cyc(3);
        `check_eq("master off", 1'b0, gnt.valid)
        @(posedge clk) begin oth <= '0; hg <= '0; gen <= 1'b1; ser <= 1'b1; end
        cyc(4);
        `check_eq("serial pulse", 1, n_ser)
        @(posedge clk) begin ser <= 1'b0; res_en <= 1'b1; wake_cmd <= 1'b1; end
        cyc(8);
        `check_eq("wake running", 1'b0, flags.resume_irq_flag)
        @(posedge clk) wake_cmd <= 1'b0;
        cyc(4);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) bus_act <= 1'b0;
            cyc(60);
            `check_eq("suspend pulses", k + 1, n_sus)
            cyc(10);
            `check_eq("osc stop", 1'b0, osc)
            `check_eq("cpu halt", 1'b1, halt)
            @(posedge clk) begin wake_cmd <= (k == 0); gres <= (k == 1); end
            cyc(8);
            `check_eq("resume flag", 1'b1, flags.resume_irq_flag)
            `check_eq("osc restart", 1'b1, osc)
            `check_eq("resume vector", 8'h33, gnt.vector)
            `check_eq("cpu run", 1'b0, halt)
            @(posedge clk) begin wake_cmd <= 1'b0; gres <= 1'b0; bus_act <= 1'b1; end
            @(posedge clk) rclr <= 1'b1;
            @(posedge clk) rclr <= 1'b0;
            cyc(3);
            `check_eq("resume clear", 1'b0, flags.resume_irq_flag)
        end
        // Bus activity alone ends idle
        @(posedge clk) bus_act <= 1'b0;
        cyc(70);
        `check_eq("suspend pulses act", 3, n_sus)
        `check_eq("osc stop act", 1'b0, osc)
        @(posedge clk) bus_act <= 1'b1;
        cyc(6);
        `check_eq("osc restart act", 1'b1, osc)
        end_of_test();
    end
endmodule : core_interrupt_and_wakeup_tb
